// ==== logic/smdlu_pkg.sv ====
// constants and types for the signed multiply/divide and logic unit
package smdlu_pkg;
  localparam int CNT_W = 10;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACC_HI = 8'h04;
  localparam logic [7:0] OFS_ACC_LO = 8'h08;
  localparam logic [7:0] OFS_IMM = 8'h0C;
  localparam logic [7:0] OFS_MEM = 8'h10;
  localparam logic [7:0] OFS_COST = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_BANK = 8'h20;
  // field positions
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_FORM_LSB = 4;
  localparam int CTL_WORD_BIT = 8;
  localparam int CTL_REG_LSB = 12;
  localparam int COST_A_LSB = 0;
  localparam int COST_B_LSB = 8;
  localparam int COST_C_LSB = 16;
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int STS_BUSY = 0;
  localparam int STS_LATE = 1;
  localparam int STS_LAST_LSB = 8;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [23:0] RST_COST = 24'h000000;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  typedef enum logic [2:0] {
    OP_DIV = 3'h0, OP_MUL = 3'h1, OP_AND = 3'h2,
    OP_OR = 3'h3, OP_XOR = 3'h4, OP_NOT = 3'h5
  } smdlu_op_t;
  typedef enum logic [2:0] {
    F_ACC = 3'h0, F_IMM = 3'h1, F_REG_SRC = 3'h2,
    F_MEM_SRC = 3'h3, F_REG_DST = 3'h4, F_MEM_DST = 3'h5
  } smdlu_form_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} smdlu_state_t;
  // execution cycle counts: zero, early overflow, late overflow, normal
  localparam int DIVB_ACC_Z = 3, DIVB_ACC_E = 8, DIVB_ACC_L = 18;
  localparam int DIVB_ACC_N = 18;
  localparam int DIVB_REG_Z = 3, DIVB_REG_E = 10, DIVB_REG_L = 21;
  localparam int DIVB_REG_N = 22;
  localparam int DIVB_MEM_Z = 4, DIVB_MEM_E = 11, DIVB_MEM_L = 22;
  localparam int DIVB_MEM_N = 23;
  localparam int SIGNED_WORD_DIVIDE_REG_Z = 4, SIGNED_WORD_DIVIDE_REG_E = 10, SIGNED_WORD_DIVIDE_REG_L = 29;
  localparam int SIGNED_WORD_DIVIDE_REG_N = 30;
  localparam int SIGNED_WORD_DIVIDE_MEM_Z = 4, SIGNED_WORD_DIVIDE_MEM_E = 11, SIGNED_WORD_DIVIDE_MEM_L = 30;
  localparam int SIGNED_WORD_DIVIDE_MEM_N = 31;
  localparam int SIGNED_WORD_DIVIDE_NEG_EXTRA = 1;
  // multiply: zero operand, positive, negative
  localparam int MULB_ACC_Z = 3, MULB_ACC_P = 12, MULB_ACC_N = 13;
  localparam int MULB_REG_Z = 3, MULB_REG_P = 12, MULB_REG_N = 13;
  localparam int MULB_MEM_Z = 4, MULB_MEM_P = 13, MULB_MEM_N = 14;
  localparam int SIGNED_WORD_MULTIPLY_ACC_Z = 3, SIGNED_WORD_MULTIPLY_ACC_P = 12, SIGNED_WORD_MULTIPLY_ACC_N = 13;
  localparam int SIGNED_WORD_MULTIPLY_REG_Z = 3, SIGNED_WORD_MULTIPLY_REG_P = 16, SIGNED_WORD_MULTIPLY_REG_N = 19;
  localparam int SIGNED_WORD_MULTIPLY_MEM_Z = 4, SIGNED_WORD_MULTIPLY_MEM_P = 17, SIGNED_WORD_MULTIPLY_MEM_N = 20;
  localparam int LOGIC_SRC = 2, LOGIC_DST = 3, LOGIC_MEM = 3;
endpackage : smdlu_pkg

// ==== logic/smdlu_top.sv ====
// signed multiply/divide and logical datapath behind an apb slave
// Notes on behaviour
// - byte divide on A: high word by low byte
// - word multiply on A: high times low, 32-bit
// - byte divide on A: 3, 8/18, 18 cycles
// - byte divide by register: 3, 10/21, 22
// - byte divide by memory: 4, 11/22, 23 plus cost
// - word divide by register: sign-dependent counts
// - word divide by memory: sign-dependent plus cost
// - memory divide: correction once, twice if normal
// - early overflow short count, late overflow long
// - byte multiply on A: 3, 12, 13
// - byte multiply by register: 3, 12, 13
// - byte multiply by memory: 4, 13, 14 plus cost
// - word multiply on A: 3, 12, 13
// - word multiply by register: 3, 16, 19
// - word multiply by memory: 4, 17, 20 plus cost
// - byte and/or/xor into accumulator low byte
// - register or memory destination written back
// - byte complement in place, memory read-modify-write
// - logic sets n and z, clears v, keeps c
// - word logic on A: high op low into low
// - word logic: immediate, register, memory, destinations
// - word complement in place, memory read-modify-write
// - logic: 2 cycles, register dest 3 (complement 2), memory 3+cost
`timescale 1ns/10ps
module smdlu_top #(
  parameter int NREG = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int CW = smdlu_pkg::CNT_W;
  localparam int RW = $clog2(NREG);

  logic [15:0] acc_hi_reg, acc_hi_next, acc_lo_reg, acc_lo_next;
  logic [15:0] imm_reg, imm_next, mem_reg, mem_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [23:0] cost_reg, cost_next;
  logic [3:0] flags_reg, flags_next;
  logic [15:0] bank_reg [NREG];
  logic [15:0] bank_next [NREG];
  smdlu_pkg::smdlu_state_t state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next, last_reg, last_next;
  logic [CW-1:0] run_len_reg, run_len_next;
  logic late_reg, late_next;
  logic [31:0] prdata_reg, prdata_next, rd, sts;

  logic acc_ph, mapped, in_bank, busy, wr, start, done;
  logic [RW-1:0] bidx, ridx;
  logic [15:0] ctl, ear, src;
  smdlu_pkg::smdlu_op_t op;
  smdlu_pkg::smdlu_form_t form;
  logic wsel, is_acc, is_mem, is_reg, is_logic;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) &&
           (a < smdlu_pkg::OFS_BANK + 8'(4 * NREG));
  endfunction : is_mapped

  // picks zero / overflow (early or late) / normal count
  function automatic logic [CW-1:0] pick(input logic z, input logic e,
      input logic o, input int cz, input int ce, input int cl,
      input int cn);
    int c;
    c = z ? cz : (o ? (e ? ce : cl) : cn);
    return CW'(c);
  endfunction : pick

  // apb decode; writes are refused while an operation runs
  assign acc_ph = psel && penable;
  assign mapped = is_mapped(paddr);
  assign in_bank = mapped && (paddr >= smdlu_pkg::OFS_BANK);
  assign bidx = RW'((paddr - smdlu_pkg::OFS_BANK) >> 2);
  assign busy = (state_reg == smdlu_pkg::ST_RUN);
  assign wr = acc_ph && pwrite && mapped && !busy;
  assign start = wr && (paddr == smdlu_pkg::OFS_CTRL);
  assign done = busy && (cnt_reg == CW'(1));
  assign pready = 1'b1;
  assign pslverr = acc_ph && (!mapped || (pwrite && busy));
  assign prdata = prdata_reg;

  // the control word is decoded straight from the bus on a start so the
  // cycle count is known in the same edge
  assign ctl = start ? pwdata[15:0] : ctrl_reg;
  assign op = smdlu_pkg::smdlu_op_t'(ctl[smdlu_pkg::CTL_OP_LSB +: 3]);
  assign form = smdlu_pkg::smdlu_form_t'(ctl[smdlu_pkg::CTL_FORM_LSB +: 3]);
  assign wsel = ctl[smdlu_pkg::CTL_WORD_BIT];
  assign ridx = ctl[smdlu_pkg::CTL_REG_LSB +: RW];
  assign is_acc = (form == smdlu_pkg::F_ACC);
  assign is_mem = (form == smdlu_pkg::F_MEM_SRC) ||
                  (form == smdlu_pkg::F_MEM_DST);
  assign is_reg = (form == smdlu_pkg::F_REG_SRC) ||
                  (form == smdlu_pkg::F_REG_DST);
  assign is_logic = (op == smdlu_pkg::OP_AND) || (op == smdlu_pkg::OP_OR) ||
                    (op == smdlu_pkg::OP_XOR) || (op == smdlu_pkg::OP_NOT);
  assign ear = bank_reg[ridx];
  // second operand: register, memory, immediate, or the high half
  assign src = is_reg ? ear : (is_mem ? mem_reg :
               ((form == smdlu_pkg::F_IMM) ? imm_reg : acc_hi_reg));

  // signed divide
  logic signed [31:0] dd, dv, dv_safe, quo, rem;
  logic [32:0] mag_dd, mag_dv, lim;
  logic dv_zero, ovf_early, ovf_late, ovf, dd_neg;
  logic [7:0] quo_b, rem_b;
  always_comb begin
    if (wsel) begin
      dd = {acc_hi_reg, acc_lo_reg};
      dv = {{16{src[15]}}, src};
    end else if (is_acc) begin
      dd = {{16{acc_hi_reg[15]}}, acc_hi_reg};
      dv = {{24{acc_lo_reg[7]}}, acc_lo_reg[7:0]};
    end else begin
      dd = {{16{acc_lo_reg[15]}}, acc_lo_reg};
      dv = {{24{src[7]}}, src[7:0]};
    end
  end
  assign dd_neg = dd[31];
  assign dv_zero = (dv == 32'sh0);
  assign dv_safe = dv_zero ? 32'sh1 : dv; // keeps the divider defined
  assign quo = dd / dv_safe;
  assign rem = dd % dv_safe;
  assign quo_b = quo[7:0];
  assign rem_b = rem[7:0];
  assign mag_dd = dd[31] ? 33'h0 - {dd[31], dd} : {1'b0, dd};
  assign mag_dv = dv[31] ? 33'h0 - {dv[31], dv} : {1'b0, dv};
  assign lim = wsel ? (mag_dv << 16) : (mag_dv << 8);
  // early: quotient magnitude surely too large, seen before dividing
  assign ovf_early = !dv_zero && (mag_dd >= lim);
  // late: found only from the quotient, e.g. +128 for a byte
  assign ovf_late = !dv_zero && !ovf_early && (wsel ?
      !((&quo[31:15]) || !(|quo[31:15])) :
      !((&quo[31:7]) || !(|quo[31:7])));
  assign ovf = ovf_early || ovf_late;

  // signed multiply
  logic [15:0] ma, mb;
  logic signed [31:0] prod;
  logic mz;
  always_comb begin
    ma = is_acc ? acc_hi_reg : acc_lo_reg;
    mb = is_acc ? acc_lo_reg : src;
    if (!wsel) begin
      ma = {{8{ma[7]}}, ma[7:0]};
      mb = {{8{mb[7]}}, mb[7:0]};
    end
    mz = is_acc ? (ma == 16'h0) : (mb == 16'h0);
    prod = $signed(ma) * $signed(mb);
  end

  // logical: x is the destination operand, y the source
  logic [15:0] lx, ly, lres, wb;
  logic dst_form;
  assign dst_form = (form == smdlu_pkg::F_REG_DST) ||
                    (form == smdlu_pkg::F_MEM_DST);
  assign lx = (form == smdlu_pkg::F_REG_DST) ? ear :
              ((form == smdlu_pkg::F_MEM_DST) ? mem_reg : acc_lo_reg);
  assign ly = dst_form ? acc_lo_reg : src;
  always_comb begin
    unique case (op)
      smdlu_pkg::OP_AND: lres = lx & ly;
      smdlu_pkg::OP_OR: lres = lx | ly;
      smdlu_pkg::OP_XOR: lres = lx ^ ly;
      smdlu_pkg::OP_NOT: lres = ~lx;
      default: lres = lx;
    endcase
  end
  // byte forms keep the upper byte of the destination
  assign wb = wsel ? lres : {lx[15:8], lres[7:0]};

  // execution cycle count for the decoded operation
  logic [CW-1:0] base, total, corr, acost;
  logic twice;
  int nx;
  always_comb begin
    base = CW'(1);
    twice = 1'b0;
    nx = dd_neg ? smdlu_pkg::SIGNED_WORD_DIVIDE_NEG_EXTRA : 0;
    unique case (op)
      smdlu_pkg::OP_DIV: begin
        twice = !(dv_zero || ovf);
        if (wsel && is_mem)
          base = pick(dv_zero, ovf_early, ovf, smdlu_pkg::SIGNED_WORD_DIVIDE_MEM_Z,
              smdlu_pkg::SIGNED_WORD_DIVIDE_MEM_E + nx, smdlu_pkg::SIGNED_WORD_DIVIDE_MEM_L + nx,
              smdlu_pkg::SIGNED_WORD_DIVIDE_MEM_N + nx);
        else if (wsel)
          base = pick(dv_zero, ovf_early, ovf, smdlu_pkg::SIGNED_WORD_DIVIDE_REG_Z,
              smdlu_pkg::SIGNED_WORD_DIVIDE_REG_E + nx, smdlu_pkg::SIGNED_WORD_DIVIDE_REG_L + nx,
              smdlu_pkg::SIGNED_WORD_DIVIDE_REG_N + nx);
        else if (is_mem)
          base = pick(dv_zero, ovf_early, ovf, smdlu_pkg::DIVB_MEM_Z,
              smdlu_pkg::DIVB_MEM_E, smdlu_pkg::DIVB_MEM_L,
              smdlu_pkg::DIVB_MEM_N);
        else if (is_acc)
          base = pick(dv_zero, ovf_early, ovf, smdlu_pkg::DIVB_ACC_Z,
              smdlu_pkg::DIVB_ACC_E, smdlu_pkg::DIVB_ACC_L,
              smdlu_pkg::DIVB_ACC_N);
        else
          base = pick(dv_zero, ovf_early, ovf, smdlu_pkg::DIVB_REG_Z,
              smdlu_pkg::DIVB_REG_E, smdlu_pkg::DIVB_REG_L,
              smdlu_pkg::DIVB_REG_N);
      end
      smdlu_pkg::OP_MUL: begin
        // early flag tied low so an overflow slot means negative
        if (wsel && is_mem)
          base = pick(mz, 1'b0, prod[31], smdlu_pkg::SIGNED_WORD_MULTIPLY_MEM_Z,
              0, smdlu_pkg::SIGNED_WORD_MULTIPLY_MEM_N, smdlu_pkg::SIGNED_WORD_MULTIPLY_MEM_P);
        else if (wsel && is_acc)
          base = pick(mz, 1'b0, prod[31], smdlu_pkg::SIGNED_WORD_MULTIPLY_ACC_Z,
              0, smdlu_pkg::SIGNED_WORD_MULTIPLY_ACC_N, smdlu_pkg::SIGNED_WORD_MULTIPLY_ACC_P);
        else if (wsel)
          base = pick(mz, 1'b0, prod[31], smdlu_pkg::SIGNED_WORD_MULTIPLY_REG_Z,
              0, smdlu_pkg::SIGNED_WORD_MULTIPLY_REG_N, smdlu_pkg::SIGNED_WORD_MULTIPLY_REG_P);
        else if (is_mem)
          base = pick(mz, 1'b0, prod[31], smdlu_pkg::MULB_MEM_Z,
              0, smdlu_pkg::MULB_MEM_N, smdlu_pkg::MULB_MEM_P);
        else if (is_acc)
          base = pick(mz, 1'b0, prod[31], smdlu_pkg::MULB_ACC_Z,
              0, smdlu_pkg::MULB_ACC_N, smdlu_pkg::MULB_ACC_P);
        else
          base = pick(mz, 1'b0, prod[31], smdlu_pkg::MULB_REG_Z,
              0, smdlu_pkg::MULB_REG_N, smdlu_pkg::MULB_REG_P);
      end
      smdlu_pkg::OP_AND, smdlu_pkg::OP_OR, smdlu_pkg::OP_XOR,
      smdlu_pkg::OP_NOT: begin
        twice = (form == smdlu_pkg::F_MEM_DST);
        if (is_mem)
          base = CW'(smdlu_pkg::LOGIC_MEM);
        else if ((form == smdlu_pkg::F_REG_DST) && (op != smdlu_pkg::OP_NOT))
          base = CW'(smdlu_pkg::LOGIC_DST);
        else
          base = CW'(smdlu_pkg::LOGIC_SRC);
      end
      default: base = CW'(1);
    endcase
  end
  assign acost = CW'(cost_reg[smdlu_pkg::COST_A_LSB +: 8]);
  assign corr = wsel ? CW'(cost_reg[smdlu_pkg::COST_C_LSB +: 8]) :
                       CW'(cost_reg[smdlu_pkg::COST_B_LSB +: 8]);
  // memory forms add the addressing cost and one or two bus corrections
  assign total = base + (is_mem ? acost : CW'(0)) +
                 (is_mem ? (twice ? CW'(corr << 1) : corr) : CW'(0));

  // sequencer: runs for exactly the computed count, commits at the end
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    last_next = last_reg;
    late_next = late_reg;
    run_len_next = busy ? run_len_reg + CW'(1) : run_len_reg;
    if (start) begin
      state_next = smdlu_pkg::ST_RUN;
      cnt_next = total;
      last_next = total;
      late_next = (op == smdlu_pkg::OP_DIV) && ovf_late;
      run_len_next = CW'(0);
    end else if (busy) begin
      cnt_next = cnt_reg - CW'(1);
      if (cnt_reg == CW'(1))
        state_next = smdlu_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= smdlu_pkg::ST_IDLE;
      cnt_reg <= '0;
      last_reg <= '0;
      late_reg <= 1'b0;
      run_len_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      last_reg <= last_next;
      late_reg <= late_next;
      run_len_reg <= run_len_next;
    end
  end

  // register file: software writes when idle, results at commit
  always_comb begin
    acc_hi_next = acc_hi_reg;
    acc_lo_next = acc_lo_reg;
    imm_next = imm_reg;
    mem_next = mem_reg;
    ctrl_next = ctrl_reg;
    cost_next = cost_reg;
    flags_next = flags_reg;
    bank_next = bank_reg;
    if (wr) begin
      if (paddr == smdlu_pkg::OFS_CTRL)
        ctrl_next = pwdata[15:0];
      if (paddr == smdlu_pkg::OFS_ACC_HI)
        acc_hi_next = pwdata[15:0];
      if (paddr == smdlu_pkg::OFS_ACC_LO)
        acc_lo_next = pwdata[15:0];
      if (paddr == smdlu_pkg::OFS_IMM)
        imm_next = pwdata[15:0];
      if (paddr == smdlu_pkg::OFS_MEM)
        mem_next = pwdata[15:0];
      if (paddr == smdlu_pkg::OFS_COST)
        cost_next = pwdata[23:0];
      if (paddr == smdlu_pkg::OFS_FLAGS)
        flags_next = pwdata[3:0];
      if (in_bank)
        bank_next[bidx] = pwdata[15:0];
    end
    if (done) begin
      unique case (op)
        smdlu_pkg::OP_DIV: begin
          flags_next[smdlu_pkg::FLG_V] = dv_zero || ovf;
          flags_next[smdlu_pkg::FLG_C] = dv_zero;
          // on error the operands are left untouched
          if (!(dv_zero || ovf)) begin
            acc_lo_next = wsel ? quo[15:0] : {acc_lo_reg[15:8], quo_b};
            if (is_acc)
              acc_hi_next = {acc_hi_reg[15:8], rem_b};
            else if (is_mem)
              mem_next = wsel ? rem[15:0] : {mem_reg[15:8], rem_b};
            else
              bank_next[ridx] = wsel ? rem[15:0] : {ear[15:8], rem_b};
          end
        end
        smdlu_pkg::OP_MUL: begin
          if (wsel)
            {acc_hi_next, acc_lo_next} = prod;
          else
            acc_lo_next = prod[15:0];
        end
        smdlu_pkg::OP_AND, smdlu_pkg::OP_OR, smdlu_pkg::OP_XOR,
        smdlu_pkg::OP_NOT: begin
          flags_next[smdlu_pkg::FLG_N] = wsel ? lres[15] : lres[7];
          flags_next[smdlu_pkg::FLG_Z] = wsel ? (lres == 16'h0) :
                                          (lres[7:0] == 8'h00);
          flags_next[smdlu_pkg::FLG_V] = 1'b0;
          if (form == smdlu_pkg::F_REG_DST)
            bank_next[ridx] = wb;
          else if (form == smdlu_pkg::F_MEM_DST)
            mem_next = wb;
          else
            acc_lo_next = wb;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      acc_hi_reg <= smdlu_pkg::RST_WORD;
      acc_lo_reg <= smdlu_pkg::RST_WORD;
      imm_reg <= smdlu_pkg::RST_WORD;
      mem_reg <= smdlu_pkg::RST_WORD;
      ctrl_reg <= smdlu_pkg::RST_WORD;
      cost_reg <= smdlu_pkg::RST_COST;
      flags_reg <= smdlu_pkg::RST_FLAGS;
      for (int i = 0; i < NREG; i++)
        bank_reg[i] <= smdlu_pkg::RST_WORD;
    end else begin
      acc_hi_reg <= acc_hi_next;
      acc_lo_reg <= acc_lo_next;
      imm_reg <= imm_next;
      mem_reg <= mem_next;
      ctrl_reg <= ctrl_next;
      cost_reg <= cost_next;
      flags_reg <= flags_next;
      bank_reg <= bank_next;
    end
  end

  // read data is captured in the setup phase, so pready can stay high
  always_comb begin
    sts = 32'h0;
    sts[smdlu_pkg::STS_BUSY] = busy;
    sts[smdlu_pkg::STS_LATE] = late_reg;
    sts[smdlu_pkg::STS_LAST_LSB +: CW] = last_reg;
    rd = 32'h0;
    if (paddr == smdlu_pkg::OFS_CTRL)
      rd = {16'h0, ctrl_reg};
    else if (paddr == smdlu_pkg::OFS_ACC_HI)
      rd = {16'h0, acc_hi_reg};
    else if (paddr == smdlu_pkg::OFS_ACC_LO)
      rd = {16'h0, acc_lo_reg};
    else if (paddr == smdlu_pkg::OFS_IMM)
      rd = {16'h0, imm_reg};
    else if (paddr == smdlu_pkg::OFS_MEM)
      rd = {16'h0, mem_reg};
    else if (paddr == smdlu_pkg::OFS_COST)
      rd = {8'h0, cost_reg};
    else if (paddr == smdlu_pkg::OFS_FLAGS)
      rd = {28'h0, flags_reg};
    else if (paddr == smdlu_pkg::OFS_STATUS)
      rd = sts;
    else if (in_bank)
      rd = {16'h0, bank_reg[bidx]};
    prdata_next = (psel && !penable) ? rd : prdata_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      prdata_reg <= 32'h0;
    else
      prdata_reg <= prdata_next;
  end

  // checks on timing and results
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  divz_acc_a: assert property (start && op == smdlu_pkg::OP_DIV && !wsel && is_acc && dv_zero |=> busy [*3] ##1 !busy) else $error("byte divide by zero length wrong");
  divb_reg_a: assert property (start && op == smdlu_pkg::OP_DIV && !wsel && form == smdlu_pkg::F_REG_SRC && !dv_zero && !ovf |=> ##21 busy ##1 !busy) else $error("byte register divide length wrong");
  signed_word_divide_neg_a: assert property (start && op == smdlu_pkg::OP_DIV && wsel && form == smdlu_pkg::F_REG_SRC && dd_neg && !dv_zero && !ovf |=> ##30 busy ##1 !busy) else $error("negative word divide length wrong");
  mulb_pos_a: assert property (start && op == smdlu_pkg::OP_MUL && !wsel && is_acc && !mz && !prod[31] |=> ##11 busy ##1 !busy) else $error("byte multiply length wrong");
  signed_word_multiply_neg_a: assert property (start && op == smdlu_pkg::OP_MUL && wsel && form == smdlu_pkg::F_REG_SRC && !mz && prod[31] |=> ##18 busy ##1 !busy) else $error("word multiply length wrong");
  logic_imm_a: assert property (start && is_logic && form == smdlu_pkg::F_IMM |=> busy [*2] ##1 !busy) else $error("logic immediate length wrong");
  run_len_a: assert property ($fell(busy) |-> run_len_reg == last_reg) else $error("busy length differs from count");
  logic_flag_a: assert property (done && is_logic |=> !flags_reg[smdlu_pkg::FLG_V] && flags_reg[smdlu_pkg::FLG_C] == $past(flags_reg[smdlu_pkg::FLG_C])) else $error("logic flags wrong");
  signed_word_multiply_res_a: assert property (done && op == smdlu_pkg::OP_MUL && wsel |=> {acc_hi_reg, acc_lo_reg} == $past(prod)) else $error("word product not written");
  divb_res_a: assert property (done && op == smdlu_pkg::OP_DIV && !wsel && is_acc && !dv_zero && !ovf |=> acc_lo_reg[7:0] == $past(quo_b) && acc_hi_reg[7:0] == $past(rem_b)) else $error("byte divide result wrong");
endmodule : smdlu_top

// ==== tb/smdlu_top_test.sv ====
// self-checking bench for the multiply/divide and logic datapath
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("BAD %s exp %0h got %0h", n, e, g); \
  end \
end
module smdlu_top_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  smdlu_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  // watchdog: the planned traffic needs well under a tenth of this
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // one apb transfer; the answer is taken at the edge that ends the access
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // read before this edge's updates land, so settled values are seen
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // start an operation, poll until idle, check the reported count
  task automatic run(input logic [31:0] ctl, input int n);
    int k;
    k = 0;
    apb(1'b1, 8'h00, ctl);
    do begin
      apb(1'b0, 8'h1C, 32'h0);
      k++;
    end while (rd[0] !== 1'b0 && k < 40);
    `CHK("idle after run", 1'b0, rd[0])
    `CHK("cycle count", n[9:0], rd[17:8])
  endtask : run
  // accumulator halves, bank entry 1 and memory word
  task automatic ld(input logic [15:0] h, l, s);
    apb(1'b1, 8'h04, {16'h0, h});
    apb(1'b1, 8'h08, {16'h0, l});
    apb(1'b1, 8'h24, {16'h0, s});
    apb(1'b1, 8'h10, {16'h0, s});
  endtask : ld
  // control word with bank index 1
  function automatic logic [31:0] mk(input logic [2:0] op, f,
                                     input logic w);
    return {17'h0, 3'h1, 3'h0, w, 1'b0, f, 1'b0, op};
  endfunction : mk
  function automatic logic [15:0] lg(input logic [2:0] op,
                                     input logic [15:0] a, b);
    case (op)
      3'h2: return a & b;
      3'h3: return a | b;
      3'h4: return a ^ b;
      default: return ~a;
    endcase
  endfunction : lg
  initial begin
    logic [2:0] op, f;
    logic w;
    logic [15:0] hi, lo, q, r;
    logic [3:0] fl;
    void'($urandom(32'h15B01954));
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, 8'h18, 32'h0);
    `CHK("flags reset", 32'h0, rd)
    apb(1'b0, 8'h44, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, 8'h14, 32'h00030205);
    // random logic ops; byte forms must keep the upper byte
    for (int i = 0; i < 12; i++) begin
      op = (i == 3) ? 3'h2 : 3'($urandom_range(5, 2));
      w = 1'($urandom);
      hi = 16'($urandom);
      lo = 16'($urandom);
      q = (i == 3) ? ~lo : 16'($urandom);
      fl = 4'($urandom);
      // forms cycle through acc, immediate, register and memory source
      f = (op == 3'h5) ? 3'h0 : 3'(i % 4);
      ld(hi, lo, q);
      apb(1'b1, 8'h0C, {16'h0, q});
      apb(1'b1, 8'h18, {28'h0, fl});
      run(mk(op, f, w), (f == 3'h3) ? (w ? 11 : 10) : 2);
      r = lg(op, lo, (f == 3'h0) ? hi : q);
      if (!w)
        r = {lo[15:8], r[7:0]};
      apb(1'b0, 8'h08, 32'h0);
      `CHK("logic result", {16'h0, r}, rd)
      apb(1'b0, 8'h18, 32'h0);
      `CHK("logic flags", {28'h0, w ? r[15] : r[7],
        w ? (r == 16'h0) : (r[7:0] == 8'h0), 1'b0, fl[0]}, rd)
    end
    ld(16'h0, 16'h12F0, 16'h3C55);
    run(mk(3'h2, 3'h4, 1'b0), 3);
    apb(1'b0, 8'h24, 32'h0);
    `CHK("reg dest", 32'h00003C50, rd)
    ld(16'h0, 16'hFF00, 16'h0F0F);
    run(mk(3'h4, 3'h5, 1'b1), 14);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("mem dest", 32'h0000F00F, rd)
    run(mk(3'h5, 3'h5, 1'b1), 14);
    apb(1'b0, 8'h10, 32'h0);
    `CHK("mem not", 32'h00000FF0, rd)
    // multiplies: zero operand, positive and negative products
    ld(16'h3, 16'h5, 16'h0);
    run(mk(3'h1, 3'h0, 1'b1), 12);
    ld(16'hFFFE, 16'h7, 16'h0);
    run(mk(3'h1, 3'h0, 1'b1), 13);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("signed_word_multiply high", 32'h0000FFFF, rd)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("signed_word_multiply low", 32'h0000FFF2, rd)
    ld(16'h0, 16'h9, 16'h0);
    run(mk(3'h1, 3'h0, 1'b1), 3);
    ld(16'h3, 16'h4, 16'h0);
    run(mk(3'h1, 3'h0, 1'b0), 12);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("mul acc byte", 32'h0000000C, rd)
    ld(16'h0, 16'h00FD, 16'h4);
    run(mk(3'h1, 3'h2, 1'b0), 13);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("mul byte", 32'h0000FFF4, rd)
    ld(16'h0, 16'h5, 16'h0);
    run(mk(3'h1, 3'h2, 1'b0), 3);
    ld(16'h0, 16'h5, 16'h3);
    run(mk(3'h1, 3'h3, 1'b0), 20);
    ld(16'h0, 16'hFFFF, 16'h2);
    run(mk(3'h1, 3'h2, 1'b1), 19);
    ld(16'h0, 16'h3, 16'h2);
    run(mk(3'h1, 3'h3, 1'b1), 25);
    // divides: normal, zero divisor, early and late overflow
    ld(16'd100, 16'h7, 16'h0);
    run(mk(3'h0, 3'h0, 1'b0), 18);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("div quotient", 8'h0E, rd[7:0])
    apb(1'b0, 8'h04, 32'h0);
    `CHK("div remainder", 8'h02, rd[7:0])
    ld(16'd100, 16'h0, 16'h0);
    run(mk(3'h0, 3'h0, 1'b0), 3);
    apb(1'b0, 8'h18, 32'h0);
    `CHK("div zero flags", 2'b11, rd[1:0])
    ld(16'h7000, 16'h2, 16'h0);
    run(mk(3'h0, 3'h0, 1'b0), 8);
    ld(16'h0100, 16'h2, 16'h0);
    run(mk(3'h0, 3'h0, 1'b0), 18);
    `CHK("late flag", 1'b1, rd[1])
    ld(16'h0, 16'd100, 16'h7);
    run(mk(3'h0, 3'h2, 1'b0), 22);
    run(mk(3'h0, 3'h3, 1'b0), 32);
    ld(16'h0, 16'd100, 16'h7);
    run(mk(3'h0, 3'h2, 1'b1), 30);
    ld(16'hFFFF, 16'hFF9C, 16'h7);
    run(mk(3'h0, 3'h2, 1'b1), 31);
    ld(16'h0, 16'd100, 16'h0);
    run(mk(3'h0, 3'h3, 1'b1), 12);
    ld(16'hFFFF, 16'hFF9C, 16'h7);
    run(mk(3'h0, 3'h3, 1'b1), 43);
    // a write during a long divide is refused and changes nothing
    ld(16'hFFFF, 16'hFF9C, 16'h7);
    apb(1'b1, 8'h00, mk(3'h0, 3'h3, 1'b1));
    apb(1'b1, 8'h08, 32'h1);
    `CHK("busy write err", 1'b1, err)
    repeat (50) @(posedge ref_clk);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("word quotient", 32'h0000FFF2, rd)
    final_report();
  end
endmodule : smdlu_top_test
